// >>> spss_sequencer.sv
// System power state sequencer: working, sleep, soft-off and AC restore.
// Assumes all pins asynchronous except the OS, policy and monitor inputs,
// which come from logic on the same 40 MHz standby clock.
`timescale 1ns/100ps
`default_nettype none

module spss_sequencer
    import spss_pkg::*;
#(
    parameter int NUM_FANS = SPSS_NUM_FANS,
    parameter int unsigned SHORT_CYC = SPSS_SHORT_CYC,
    parameter int unsigned LONG_CYC = SPSS_LONG_CYC,
    parameter bit DUAL_LED = 1'b1
) (
    input wire logic clock,                              // Standby clock
    input wire logic rstn,                               // Asynchronous reset, active low
    input wire logic pwr_sw_n,                           // Front panel switch pin
    input wire logic pwr_good,                           // Supply power good pin
    input wire spss_wake_t wake,                         // Wake source pins
    input wire logic [NUM_FANS-1:0] fan_tach,            // Fan tachometer pins
    input wire spss_policy_t policy,                     // Last-state policy setting
    input wire logic last_on,                            // Retained state before AC loss
    input wire logic sleep_to_disk,                      // Sleep target: 1 disk, 0 RAM
    input wire logic sleep_cmd,                          // OS sleep request pulse
    input wire logic soft_off_cmd,                       // OS soft-off request pulse
    input wire logic [NUM_FANS-1:0] fan_sw,              // Monitor per-fan on/off
    input wire logic [NUM_FANS-1:0][SPSS_PWM_W-1:0] fan_duty, // Monitor PWM duty
    output logic ps_on_n,                                // Supply remote on, active low
    output logic mem_rail_en,                            // Memory rails enable
    output logic host_rst_n,                             // Platform reset, active low
    output logic cold_boot,                              // Session began with cold boot
    output spss_led_t led,                               // Front panel indicators
    output logic [NUM_FANS-1:0] fan_en,                  // Fan power enables
    output logic [NUM_FANS-1:0] fan_pwm,                 // Fan PWM drive
    output logic [NUM_FANS-1:0] tach_mon,                // Tach to monitor
    output logic last_on_save,                           // State to retain over AC loss
    output spss_state_t sys_state                        // Current system state
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    generate
        if (NUM_FANS < 1 || SHORT_CYC < 1 || SHORT_CYC >= LONG_CYC
            || LONG_CYC >= (64'h1 << SPSS_CNT_W)) begin : g_bad
            $error("spss_sequencer: unsupported parameter values");
        end
    endgenerate

    localparam int SW = SPSS_SYN_TACH + NUM_FANS;
    localparam logic [SPSS_CNT_W-1:0] SHORT_LIM = SPSS_CNT_W'(SHORT_CYC);
    localparam logic [SPSS_CNT_W-1:0] LONG_LIM = SPSS_CNT_W'(LONG_CYC);
    localparam logic [SPSS_BOOT_W-1:0] BOOT_LIM = SPSS_BOOT_W'(SPSS_BOOT_CYC);
    localparam logic [SPSS_RESTORE_W-1:0] RESTORE_LIM = SPSS_RESTORE_W'(SPSS_RESTORE_CYC);

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic [SW-1:0] syn;
    logic [SW-1:0] syn_q;
    logic pressed;
    spss_wake_t wake_rise;

    spss_sync #(
        .W(SW),
        .INIT({{NUM_FANS{1'b0}}, SPSS_SYN_IDLE})
    ) u_sync (
        .clock(clock),
        .rstn(rstn),
        .din({fan_tach, wake.pcie_n, wake.usb, wake.lan, wake.rtc, pwr_good, pwr_sw_n}),
        .dout(syn)
    );

    // Previous filtered levels for edge detection
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            syn_q <= {{NUM_FANS{1'b0}}, SPSS_SYN_IDLE};
        end else begin
            syn_q <= syn;
        end
    end

    assign pressed = !syn[SPSS_SYN_SW];
    assign wake_rise.rtc = syn[SPSS_SYN_RTC] && !syn_q[SPSS_SYN_RTC];
    assign wake_rise.lan = syn[SPSS_SYN_LAN] && !syn_q[SPSS_SYN_LAN];
    assign wake_rise.usb = syn[SPSS_SYN_USB] && !syn_q[SPSS_SYN_USB];
    assign wake_rise.pcie_n = !syn[SPSS_SYN_PCIE] && syn_q[SPSS_SYN_PCIE];

    // ----------------------------------------------------------------
    // Press length measurement
    // ----------------------------------------------------------------
    logic [SPSS_CNT_W-1:0] press_cnt;
    logic was_pressed;
    logic short_ev;
    logic long_hit;

    // Count held cycles, saturating at the fail-safe limit
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            press_cnt <= '0;
            was_pressed <= 1'b0;
        end else begin
            was_pressed <= pressed;
            if (!pressed) begin
                press_cnt <= '0;
            end else if (press_cnt != LONG_LIM) begin
                press_cnt <= press_cnt + 1'b1;
            end
        end
    end

    // Release under four seconds is a short press; mid presses fall through
    assign short_ev = was_pressed && !pressed && (press_cnt < SHORT_LIM);
    assign long_hit = pressed && (press_cnt == LONG_LIM - 1'b1);

    // ----------------------------------------------------------------
    // State machine
    // ----------------------------------------------------------------
    spss_state_t state;
    spss_state_t next_state;
    logic [SPSS_RESTORE_W-1:0] restore_cnt;
    logic restore_done;

    assign restore_done = (restore_cnt == RESTORE_LIM);

    // Let synchronised pins settle before acting after power returns
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            restore_cnt <= '0;
        end else if (!restore_done) begin
            restore_cnt <= restore_cnt + 1'b1;
        end
    end

    // Next state selection; fail-safe hold beats every other event in the working and sleep states
    always_comb begin
        next_state = state;
        case (state)
            SPSS_ST_RESTORE: begin
                if (restore_done) begin
                    case (policy)
                        SPSS_POL_ON: next_state = SPSS_ST_WORK;
                        SPSS_POL_LAST: next_state = last_on ? SPSS_ST_WORK : SPSS_ST_SOFT_OFF;
                        default: next_state = SPSS_ST_SOFT_OFF;
                    endcase
                end
            end
            SPSS_ST_WORK: begin
                if (long_hit || soft_off_cmd) begin
                    next_state = SPSS_ST_SOFT_OFF;
                end else if (short_ev || sleep_cmd) begin
                    next_state = sleep_to_disk ? SPSS_ST_STD : SPSS_ST_STR;
                end
            end
            SPSS_ST_STR: begin
                if (long_hit) begin
                    next_state = SPSS_ST_SOFT_OFF;
                end else if (short_ev || wake_rise.rtc || wake_rise.lan || wake_rise.usb
                             || wake_rise.pcie_n) begin
                    next_state = SPSS_ST_WORK;
                end
            end
            SPSS_ST_STD: begin
                if (long_hit) begin
                    next_state = SPSS_ST_SOFT_OFF;
                end else if (short_ev || wake_rise.rtc || wake_rise.lan || wake_rise.pcie_n) begin
                    next_state = SPSS_ST_WORK;
                end
            end
            SPSS_ST_SOFT_OFF: begin
                if (short_ev || wake_rise.rtc || wake_rise.lan || wake_rise.pcie_n) begin
                    next_state = SPSS_ST_WORK;
                end
            end
            default: next_state = SPSS_ST_SOFT_OFF;
        endcase
    end

    // State register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= SPSS_ST_RESTORE;
        end else begin
            state <= next_state;
        end
    end

    assign sys_state = state;

    // ----------------------------------------------------------------
    // Supply, reset and retained state
    // ----------------------------------------------------------------
    logic [SPSS_BOOT_W-1:0] boot_cnt;

    // Supply outputs follow the next state so they align with the state
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ps_on_n <= 1'b1;
            mem_rail_en <= 1'b0;
        end else begin
            ps_on_n <= (next_state != SPSS_ST_WORK);
            mem_rail_en <= (next_state == SPSS_ST_WORK) || (next_state == SPSS_ST_STR);
        end
    end

    // Resume from RAM keeps context; any other entry is a cold boot
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cold_boot <= 1'b1;
        end else if (next_state == SPSS_ST_WORK && state != SPSS_ST_WORK) begin
            cold_boot <= (state != SPSS_ST_STR);
        end
    end

    // Hold platform reset until power good plus boot delay
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            boot_cnt <= '0;
            host_rst_n <= 1'b0;
        end else if (state != SPSS_ST_WORK || !syn[SPSS_SYN_PG]) begin
            boot_cnt <= '0;
            host_rst_n <= 1'b0;
        end else if (boot_cnt != BOOT_LIM) begin
            boot_cnt <= boot_cnt + 1'b1;
        end else begin
            host_rst_n <= 1'b1;
        end
    end

    // On/off state retained outside for the next AC return
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            last_on_save <= 1'b0;
        end else if (state != SPSS_ST_RESTORE) begin
            last_on_save <= (state != SPSS_ST_SOFT_OFF);
        end
    end

    // ----------------------------------------------------------------
    // Indicators
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            led <= '{main: 1'b0, alt: 1'b0, stby: 1'b1};
        end else begin
            led.main <= (next_state == SPSS_ST_WORK);
            led.alt <= DUAL_LED && (next_state == SPSS_ST_STR);
            led.stby <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Fans
    // ----------------------------------------------------------------
    logic [SPSS_PWM_W-1:0] pwm_cnt;

    // Free-running PWM period counter
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pwm_cnt <= '0;
        end else begin
            pwm_cnt <= pwm_cnt + 1'b1;
        end
    end

    generate
        for (genvar i = 0; i < NUM_FANS; i++) begin : g_fan
            // Enable only while working and the monitor wants the fan on
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    fan_en[i] <= 1'b0;
                    fan_pwm[i] <= 1'b0;
                    tach_mon[i] <= 1'b0;
                end else begin
                    fan_en[i] <= (state == SPSS_ST_WORK) && fan_sw[i];
                    fan_pwm[i] <= fan_en[i] && (pwm_cnt < fan_duty[i]);
                    tach_mon[i] <= syn[SPSS_SYN_TACH + i];
                end
            end

            property p_pwm_off;
                @(posedge clock) disable iff (!rstn)
                !fan_en[i] |=> !fan_pwm[i];
            endproperty
            a_pwm_off: assert property (p_pwm_off) else $error("PWM active on disabled fan");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_leave_off;
        state == SPSS_ST_SOFT_OFF ##1 state == SPSS_ST_WORK;
    endsequence

    property p_power_on;
        state == SPSS_ST_SOFT_OFF && short_ev |=> state == SPSS_ST_WORK;
    endproperty
    a_power_on: assert property (p_power_on) else $error("Short press in soft-off ignored");

    property p_sleep;
        state == SPSS_ST_WORK && short_ev && !long_hit && !soft_off_cmd
            |=> state == (sleep_to_disk ? SPSS_ST_STD : SPSS_ST_STR);
    endproperty
    a_sleep: assert property (p_sleep) else $error("Short press while working did not sleep");

    property p_fail_safe;
        state inside {SPSS_ST_WORK, SPSS_ST_STR, SPSS_ST_STD} && long_hit
            |=> state == SPSS_ST_SOFT_OFF ##0 ps_on_n;
    endproperty
    a_fail_safe: assert property (p_fail_safe) else $error("Long hold did not force soft-off");

    property p_mid_press;
        state == SPSS_ST_WORK && was_pressed && !pressed && press_cnt >= SHORT_LIM
            && !sleep_cmd && !soft_off_cmd |=> $stable(state);
    endproperty
    a_mid_press: assert property (p_mid_press) else $error("Mid-length press changed state");

    property p_restore;
        state == SPSS_ST_RESTORE && restore_done && policy == SPSS_POL_LAST
            |=> state == ($past(last_on) ? SPSS_ST_WORK : SPSS_ST_SOFT_OFF);
    endproperty
    a_restore: assert property (p_restore) else $error("Last-state restore wrong");

    property p_soft_off_cmd;
        state == SPSS_ST_WORK && soft_off_cmd |=> state == SPSS_ST_SOFT_OFF && ps_on_n;
    endproperty
    a_soft_off_cmd: assert property (p_soft_off_cmd) else $error("Soft-off left supply on");

    property p_str_outputs;
        state == SPSS_ST_STR |-> ps_on_n && mem_rail_en && !led.main && led.alt == DUAL_LED;
    endproperty
    a_str_outputs: assert property (p_str_outputs) else $error("Suspend-to-RAM outputs wrong");

    property p_cold_boot;
        s_leave_off |-> cold_boot && !host_rst_n;
    endproperty
    a_cold_boot: assert property (p_cold_boot) else $error("Soft-off exit skipped cold boot");

    property p_usb_std;
        state == SPSS_ST_STD && wake_rise.usb && !wake_rise.rtc && !wake_rise.lan
            && !wake_rise.pcie_n && !short_ev && !long_hit |=> state == SPSS_ST_STD;
    endproperty
    a_usb_std: assert property (p_usb_std) else $error("USB woke from suspend-to-disk");

    property p_pcie_wake;
        state inside {SPSS_ST_STR, SPSS_ST_STD, SPSS_ST_SOFT_OFF} && wake_rise.pcie_n && !long_hit
            |=> state == SPSS_ST_WORK;
    endproperty
    a_pcie_wake: assert property (p_pcie_wake) else $error("PCIe wake ignored");

    property p_rtc_wake;
        state == SPSS_ST_SOFT_OFF && wake_rise.rtc |=> state == SPSS_ST_WORK ##0 !ps_on_n;
    endproperty
    a_rtc_wake: assert property (p_rtc_wake) else $error("Alarm did not wake soft-off");

    property p_fans;
        state != SPSS_ST_WORK |=> fan_en == '0;
    endproperty
    a_fans: assert property (p_fans) else $error("Fan enabled outside working state");

    property p_stby_led;
        led.stby;
    endproperty
    a_stby_led: assert property (p_stby_led) else $error("Standby indicator dark");

endmodule : spss_sequencer

`default_nettype wire

// >>> spss_pkg.sv
// Package for the system power state sequencer: timing counts, states,
// policy codes, carrier structs and bit positions of the synchroniser bus.
// Assumes a single 40 MHz standby-domain clock.
package spss_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned SPSS_CLK_HZ = 40_000_000;
    localparam int unsigned SPSS_PRESS_SHORT_MS = 4000;  // Short press limit
    localparam int unsigned SPSS_PRESS_LONG_MS = 6000;   // Fail-safe hold time
    localparam int unsigned SPSS_SHORT_CYC = SPSS_PRESS_SHORT_MS * (SPSS_CLK_HZ / 1000);
    localparam int unsigned SPSS_LONG_CYC = SPSS_PRESS_LONG_MS * (SPSS_CLK_HZ / 1000);
    localparam int unsigned SPSS_BOOT_DLY_US = 100;      // Reset hold after power good
    localparam int unsigned SPSS_BOOT_CYC =
        (SPSS_BOOT_DLY_US * (SPSS_CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned SPSS_RESTORE_CYC = 5;        // Settle time of synchronised pins

    // ----------------------------------------------------------------
    // Widths and defaults
    // ----------------------------------------------------------------
    localparam int SPSS_CNT_W = 28;
    localparam int SPSS_BOOT_W = 12;
    localparam int SPSS_RESTORE_W = 3;
    localparam int SPSS_PWM_W = 8;
    localparam int SPSS_NUM_FANS = 2;

    // ----------------------------------------------------------------
    // Synchroniser bus bit positions and idle levels
    // ----------------------------------------------------------------
    localparam int SPSS_SYN_SW = 0;
    localparam int SPSS_SYN_PG = 1;
    localparam int SPSS_SYN_RTC = 2;
    localparam int SPSS_SYN_LAN = 3;
    localparam int SPSS_SYN_USB = 4;
    localparam int SPSS_SYN_PCIE = 5;
    localparam int SPSS_SYN_TACH = 6;
    localparam logic [5:0] SPSS_SYN_IDLE = 6'h21;        // Switch and PCIe wake idle high

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SPSS_ST_RESTORE  = 3'h4,
        SPSS_ST_SOFT_OFF = 3'h0,
        SPSS_ST_WORK     = 3'h1,
        SPSS_ST_STR      = 3'h3,
        SPSS_ST_STD      = 3'h2
    } spss_state_t;

    typedef enum logic [1:0] {
        SPSS_POL_OFF  = 2'h0,
        SPSS_POL_ON   = 2'h1,
        SPSS_POL_LAST = 2'h2
    } spss_policy_t;

    typedef struct packed {
        logic rtc;     // Alarm matured
        logic lan;     // Network wake packet seen
        logic usb;     // USB bus activity
        logic pcie_n;  // PCIe wake sideband, active low
    } spss_wake_t;

    typedef struct packed {
        logic main;    // Main colour of front panel LED
        logic alt;     // Amber colour of front panel LED
        logic stby;    // Standby power indicator
    } spss_led_t;

endpackage : spss_pkg

// >>> spss_sync.sv
// Three-flop pin synchroniser with agreement filter, one lane per bit.
// Assumes asynchronous pins; output changes only when stages 2 and 3 agree.
`timescale 1ns/100ps
`default_nettype none

module spss_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clock,          // Standby clock
    input wire logic rstn,           // Asynchronous reset, active low
    input wire logic [W-1:0] din,    // Raw pin levels
    output logic [W-1:0] dout        // Filtered synchronous levels
);

    // ----------------------------------------------------------------
    // Per-bit lanes
    // ----------------------------------------------------------------
    generate
        if (W < 1) begin : g_bad
            $error("spss_sync: width must be at least 1");
        end
        for (genvar i = 0; i < W; i++) begin : g_lane
            logic [2:0] stage;
            // Shift chain; only stage 1 reads stage 0
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    stage <= {3{INIT[i]}};
                end else begin
                    stage <= {stage[1:0], din[i]};
                end
            end
            // Accept a new level once stages 2 and 3 agree
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    dout[i] <= INIT[i];
                end else if (stage[1] == stage[2]) begin
                    dout[i] <= stage[2];
                end
            end
        end
    endgenerate

endmodule : spss_sync

`default_nettype wire

// >>> spss_psu_model.sv
// Power supply model at the far side of the sequencer's remote-on output.
// Assumes the sequencer's 40 MHz standby clock and an active-low request.
`timescale 1ns/100ps
`default_nettype none

module spss_psu_model #(
    parameter int DLY = 3
) (
    input wire logic clock,   // Standby clock
    input wire logic ps_on_n, // Remote on request, active low
    output logic pwr_good     // Main rails good
);
    int cnt;

    initial begin
        cnt = 0;
        pwr_good = 1'b0;
    end

    // Rails rise a few cycles after the request; all drop at once on release
    always @(posedge clock) begin
        if (ps_on_n) begin
            cnt <= 0;
            pwr_good <= 1'b0;
        end else if (cnt < DLY) begin
            cnt <= cnt + 1;
        end else begin
            pwr_good <= 1'b1;
        end
    end
endmodule : spss_psu_model

`default_nettype wire

// >>> system_power_state_sequencer_tb.sv
// Testbench for the power state sequencer with shortened press counts.
// Assumes the supply model file is compiled before this one.
`timescale 1ns/100ps
`default_nettype none

module system_power_state_sequencer_tb;
    import spss_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic pwr_sw_n = 1'b1;
    logic pwr_good;
    spss_wake_t wake = 4'h1;
    logic sleep_to_disk = 1'b0;
    logic sleep_cmd = 1'b0;
    logic soft_off_cmd = 1'b0;
    spss_policy_t policy = SPSS_POL_ON;
    logic last_on = 1'b0;
    logic host_rst_n, last_on_save;
    logic [1:0] fan_tach = 2'h0;
    logic ps_on_n, mem_rail_en, cold_boot;
    spss_led_t led;
    logic [1:0] fan_en, tach_mon, fan_pwm;
    spss_state_t sys_state;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;

    // ----------------------------------------------------------------
    // Clock, design and supply
    // ----------------------------------------------------------------
    always #12.5 clock = ~clock;

    spss_sequencer #(.SHORT_CYC(20), .LONG_CYC(40)) dut_u (
        .clock(clock), .rstn(rstn), .pwr_sw_n(pwr_sw_n), .pwr_good(pwr_good),
        .wake(wake), .fan_tach(fan_tach), .policy(policy), .last_on(last_on),
        .sleep_to_disk(sleep_to_disk), .sleep_cmd(sleep_cmd),
        .soft_off_cmd(soft_off_cmd), .fan_sw(2'h1), .fan_duty(16'h00FF),
        .ps_on_n(ps_on_n), .mem_rail_en(mem_rail_en), .host_rst_n(host_rst_n),
        .cold_boot(cold_boot), .led(led), .fan_en(fan_en), .fan_pwm(fan_pwm),
        .tach_mon(tach_mon), .last_on_save(last_on_save), .sys_state(sys_state)
    );

    spss_psu_model psu_u (.clock(clock), .ps_on_n(ps_on_n), .pwr_good(pwr_good));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc

    task check(input string name, input logic [2:0] seen, input logic [2:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask : check

    // Hold the switch low for n cycles, then let the filter see the release
    task press(input int n);
        pwr_sw_n = 1'b0;
        cyc(n);
        pwr_sw_n = 1'b1;
        cyc(8);
    endtask : press

    // Drive one wake pin to its active level (index into the wake bus), then return it idle
    task kick(input int i);
        wake[i] = ~wake[i];
        cyc(8);
        wake[i] = ~wake[i];
        cyc(6);
    endtask : kick

    // Drop standby power with a restore policy, then let the sequencer settle
    task ac_loss(input spss_policy_t pol, input logic on);
        policy = pol;
        last_on = on;
        rstn = 1'b0;
        cyc(4);
        rstn = 1'b1;
        cyc(12);
    endtask : ac_loss

    task report_and_stop;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 9000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_restore_and_sleep;
        ac_loss(SPSS_POL_ON, 1'b0);
        check("state", sys_state, SPSS_ST_WORK);
        check("fan_en", {1'b0, fan_en}, 3'h1);
        check("pwm", {1'b0, fan_pwm}, 3'h1);
        check("host_rst_n", {2'h0, host_rst_n}, 3'h0);
        check("stby", {2'h0, led.stby}, 3'h1);
        fan_tach = 2'h2;
        cyc(8);
        check("tach", {1'b0, tach_mon}, 3'h2);
        cyc(SPSS_BOOT_CYC);
        check("host_rst_n", {2'h0, host_rst_n}, 3'h1);
        press(30);
        check("state", sys_state, SPSS_ST_WORK);
        press(10);
        check("state", sys_state, SPSS_ST_STR);
        check("supply", {1'b0, ps_on_n, mem_rail_en}, 3'h3);
        check("alt", {2'h0, led.alt}, 3'h1);
        check("fan_en", {1'b0, fan_en}, 3'h0);
        kick(3'd1);
        check("state", sys_state, SPSS_ST_WORK);
        check("cold", {2'h0, cold_boot}, 3'h0);
        $display("test restore_and_sleep done");
    endtask : t_restore_and_sleep

    task t_off_paths;
        press(50);
        check("state", sys_state, SPSS_ST_SOFT_OFF);
        check("rails", {1'b0, ps_on_n, mem_rail_en}, 3'h2);
        check("saved", {2'h0, last_on_save}, 3'h0);
        kick(1);
        check("state", sys_state, SPSS_ST_SOFT_OFF);
        kick(3);
        check("state", sys_state, SPSS_ST_WORK);
        check("cold", {2'h0, cold_boot}, 3'h1);
        soft_off_cmd = 1'b1;
        cyc(1);
        soft_off_cmd = 1'b0;
        cyc(4);
        check("state", sys_state, SPSS_ST_SOFT_OFF);
        kick(2);
        check("state", sys_state, SPSS_ST_WORK);
        $display("test off_paths done");
    endtask : t_off_paths

    task t_disk_and_press;
        sleep_to_disk = 1'b1;
        sleep_cmd = 1'b1;
        cyc(1);
        sleep_cmd = 1'b0;
        cyc(4);
        check("state", sys_state, SPSS_ST_STD);
        kick(1);
        check("state", sys_state, SPSS_ST_STD);
        kick(0);
        check("state", sys_state, SPSS_ST_WORK);
        sleep_to_disk = 1'b0;
        press(10);
        press(10);
        check("state", sys_state, SPSS_ST_WORK);
        press(50);
        press(10);
        check("state", sys_state, SPSS_ST_WORK);
        $display("test disk_and_press done");
    endtask : t_disk_and_press

    // Mid-run power loss under the last-state and off restore policies
    task t_ac_restore;
        check("saved", {2'h0, last_on_save}, 3'h1);
        ac_loss(SPSS_POL_LAST, 1'b0);
        check("state", sys_state, SPSS_ST_SOFT_OFF);
        check("saved", {2'h0, last_on_save}, 3'h0);
        ac_loss(SPSS_POL_LAST, 1'b1);
        check("state", sys_state, SPSS_ST_WORK);
        check("cold", {2'h0, cold_boot}, 3'h1);
        ac_loss(SPSS_POL_OFF, 1'b1);
        check("state", sys_state, SPSS_ST_SOFT_OFF);
        $display("test ac_restore done");
    endtask : t_ac_restore

    initial begin
        t_restore_and_sleep();
        t_off_paths();
        t_disk_and_press();
        t_ac_restore();
        report_and_stop();
    end
endmodule : system_power_state_sequencer_tb

`default_nettype wire
